// file: rtl/watchdog_ctrl.sv
// Watchdog control block with timed unlock, safety levels and an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
module watchdog_ctrl
  import wdt_pkg::*;
#(
  parameter int BASE_CYC = BASE_OSC_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        wdt_osc,
  input  wire logic        safety_level_fuse,
  output      logic        chip_reset_req,
  output      logic        irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                 osc_s1_r;
  logic                 osc_s2_r;
  logic                 osc_s3_r;
  logic                 fuse_s1_r;
  logic                 fuse_s2_r;
  logic [1:0]           strap_cnt_r;
  logic                 level2_r;
  logic                 on_r;
  logic [SEL_W-1:0]     sel_r;
  logic                 unlock_r;
  logic [1:0]           unlock_cnt_r;
  logic [EV_W-1:0]      stat_r;
  logic [EV_W-1:0]      mask_r;
  logic                 kick_r;
  logic                 aw_hold_r;
  logic [7:0]           aw_addr_r;
  logic                 w_hold_r;
  logic [31:0]          w_data_r;
  logic [3:0]           w_strb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  logic [1:0]           rresp_r;
  logic                 expire_w;

  logic                 osc_tick_w;
  logic                 on_eff_w;
  logic                 do_write_w;
  logic                 wr_lane0_w;
  logic                 wr_ctrl_w;
  logic                 wr_stat_w;
  logic                 wr_mask_w;
  logic                 wr_kick_w;
  logic                 wr_hit_w;
  logic                 rd_take_w;
  logic                 rd_hit_w;
  logic [31:0]          rd_mux_w;
  logic                 wd_on_w;
  logic                 wd_unlock_w;
  logic [SEL_W-1:0]     wd_sel_w;
  logic                 clear_ok_w;
  logic                 on_nxt;
  logic [SEL_W-1:0]     sel_nxt;
  logic                 refuse_w;
  logic [EV_W-1:0]      ev_set_w;
  logic [EV_W-1:0]      ev_clr_w;
  logic [EV_W-1:0]      stat_nxt;
  logic [CTRL_W-1:0]    ctrl_rd_w;
  logic                 restart_w;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
    end else if (clk_en) begin
      osc_s1_r  <= wdt_osc;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      fuse_s1_r <= safety_level_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  assign osc_tick_w = osc_s2_r && !osc_s3_r;

  // ****************************************************************
  // Fuse capture
  // ****************************************************************
  // The level follows the synchronised fuse until it has settled after
  // reset, then stays fixed until the next reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_cnt_r <= 2'h0;
      level2_r    <= 1'b0;
    end else if (clk_en && (strap_cnt_r != 2'h3)) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      level2_r    <= fuse_s2_r;
    end
  end

  assign on_eff_w = on_r || level2_r;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = clk_en && !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = clk_en && !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  assign do_write_w = clk_en && aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_lane0_w = do_write_w && w_strb_r[0];
  assign wr_ctrl_w  = wr_lane0_w && (aw_addr_r == CTRL_OFFSET);
  assign wr_stat_w  = wr_lane0_w && (aw_addr_r == STAT_OFFSET);
  assign wr_mask_w  = wr_lane0_w && (aw_addr_r == MASK_OFFSET);
  assign wr_kick_w  = wr_lane0_w && (aw_addr_r == KICK_OFFSET);
  assign wr_hit_w   = (aw_addr_r == CTRL_OFFSET) || (aw_addr_r == STAT_OFFSET)
                   || (aw_addr_r == MASK_OFFSET) || (aw_addr_r == KICK_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write_w) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control register update
  // ****************************************************************
  assign wd_on_w     = w_data_r[TIMER_ON_BIT];
  assign wd_unlock_w = w_data_r[UNLOCK_BIT];
  assign wd_sel_w    = w_data_r[SEL_LSB +: SEL_W];

  assign clear_ok_w = unlock_r && !level2_r;

  assign on_nxt = wd_on_w ? 1'b1 : (clear_ok_w ? 1'b0 : on_r);

  assign sel_nxt = unlock_r ? wd_sel_w : sel_r;

  assign refuse_w = wr_ctrl_w && ((!wd_on_w && on_eff_w && !clear_ok_w)
                                  || (!unlock_r && (wd_sel_w != sel_r)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_r  <= ON_RESET;
      sel_r <= SEL_RESET;
    end else if (clk_en && wr_ctrl_w) begin
      on_r  <= on_nxt;
      sel_r <= sel_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 2'h0;
    end else if (clk_en) begin
      if (wr_ctrl_w && wd_unlock_w) begin
        unlock_r     <= 1'b1;
        unlock_cnt_r <= 2'(UNLOCK_CYCLES - 1);
      end else if (unlock_r) begin
        if (unlock_cnt_r == 2'h0) begin
          unlock_r <= 1'b0;
        end else begin
          unlock_cnt_r <= unlock_cnt_r - 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Status, mask, kick and interrupt
  // ****************************************************************
  assign ev_set_w = {refuse_w, expire_w};
  assign ev_clr_w = wr_stat_w ? w_data_r[EV_W-1:0] : '0;
  // A new event wins over a clear in the same cycle.
  assign stat_nxt = (stat_r & ~ev_clr_w) | ev_set_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= EV_RESET;
      mask_r <= EV_RESET;
      kick_r <= 1'b0;
    end else if (clk_en) begin
      stat_r <= stat_nxt;
      kick_r <= wr_kick_w && w_data_r[KICK_BIT];
      if (wr_mask_w) begin
        mask_r <= w_data_r[EV_W-1:0];
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************************************
  // Watchdog counter
  // ****************************************************************
  // Restart on kick or disable.
  assign restart_w = kick_r || !on_eff_w;

  wdt_counter #(
    .CNT_W (WDT_CNT_W),
    .BASE  (BASE_CYC)
  ) u_counter (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_en   (clk_en),
    .restart  (restart_w),
    .tick     (osc_tick_w),
    .sel      (sel_r),
    .count_r  (),
    .expire_r (expire_w)
  );

  assign chip_reset_req = expire_w;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Reserved bits zero.
  assign ctrl_rd_w = {3'h0, unlock_r, on_eff_w, sel_r};

  assign rd_hit_w = (s_axi_araddr[7:2] == CTRL_OFFSET[7:2])
                 || (s_axi_araddr[7:2] == STAT_OFFSET[7:2])
                 || (s_axi_araddr[7:2] == MASK_OFFSET[7:2])
                 || (s_axi_araddr[7:2] == KICK_OFFSET[7:2])
                 || (s_axi_araddr[7:2] == INFO_OFFSET[7:2]);

  always_comb begin
    rd_mux_w = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      CTRL_OFFSET: rd_mux_w[CTRL_W-1:0] = ctrl_rd_w;
      STAT_OFFSET: rd_mux_w[EV_W-1:0]   = stat_r;
      MASK_OFFSET: rd_mux_w[EV_W-1:0]   = mask_r;
      INFO_OFFSET: begin
        rd_mux_w[INFO_LEVEL_BIT] = level2_r;
        rd_mux_w[INFO_RUN_BIT]   = on_eff_w;
        rd_mux_w[INFO_OPEN_BIT]  = unlock_r;
      end
      default: rd_mux_w = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = clk_en && !rvalid_r;
  assign rd_take_w     = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (clk_en) begin
      if (rd_take_w) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux_w;
        rresp_r  <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/wdt_counter.sv
// Watchdog counter that counts oscillator ticks and flags expiry of the selected period.
module wdt_counter
  import wdt_pkg::*;
#(
  parameter int CNT_W = WDT_CNT_W,
  parameter int BASE  = BASE_OSC_CYC
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic             restart,
  input  wire logic             tick,
  input  wire logic [SEL_W-1:0] sel,
  output      logic [CNT_W-1:0] count_r,
  output      logic             expire_r
);

  logic [CNT_W-1:0] base_w;
  logic [CNT_W-1:0] limit_w;
  logic             last_w;

  assign base_w  = CNT_W'(BASE - 1);
  // The period doubles with each step of the select code.
  assign limit_w = ((base_w + CNT_W'(1)) << sel) - CNT_W'(1);
  // Reaching or passing the limit expires, so a shorter period chosen mid-count still fires.
  assign last_w  = tick && (count_r >= limit_w);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else if (clk_en) begin
      expire_r <= last_w && !restart;
      if (restart || last_w) begin
        count_r <= '0;
      end else if (tick) begin
        count_r <= count_r + CNT_W'(1);
      end
    end
  end

endmodule

// file: rtl/wdt_pkg.sv
// Package with register map, field layout and timing counts of the watchdog control block.
package wdt_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] KICK_OFFSET = 8'h0C;
  localparam logic [7:0] INFO_OFFSET = 8'h10;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 3;
  localparam int TIMER_ON_BIT = 3;
  localparam int UNLOCK_BIT   = 4;
  localparam int CTRL_W       = 8;

  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic             ON_RESET  = 1'b0;

  // ****************************************************************
  // Status, mask, kick and info fields
  // ****************************************************************
  localparam int EV_TIMEOUT_BIT = 0;
  localparam int EV_REFUSED_BIT = 1;
  localparam int EV_W           = 2;
  localparam int KICK_BIT       = 0;
  localparam int INFO_LEVEL_BIT = 0;
  localparam int INFO_RUN_BIT   = 1;
  localparam int INFO_OPEN_BIT  = 2;

  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int UNLOCK_CYCLES = 4;
  localparam int BASE_OSC_CYC  = 16384;
  localparam int WDT_CNT_W     = 22;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: tb/test_watchdog_ctrl.sv
// Self-checking bench of the watchdog control block.
module test_watchdog_ctrl
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 4;
  logic        aclk = 0, aresetn = 0, clk_en = 1, wdt_osc = 0, safety_level_fuse = 0;
  logic        chip_reset_req, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_bready = 1, s_axi_rready = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures = 0, num_checks = 0, ticks = 0, last = 0, gap = 0, pulses = 0, p;

  watchdog_ctrl #(.BASE_CYC(BASE)) watchdog_ctrl_inst (.*);

  always #50 aclk = ~aclk;
  // The oscillator runs at 1 MHz, a tenth of aclk, with every edge 87 ns after an aclk rising edge.
  initial #37 forever #500 wdt_osc = ~wdt_osc;
  always @(posedge wdt_osc) ticks++;
  always @(posedge aclk) if (chip_reset_req === 1'b1) begin
    pulses++;
    gap = ticks - last;
    last = ticks;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd_reg(logic [7:0] a, logic [7:0] exp, logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", {24'h0, exp}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic do_reset(logic fuse);
    safety_level_fuse <= fuse;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  task automatic wait_pulse();
    p = pulses;
    while (pulses == p) @(posedge aclk);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #8000000;
    failures++;
    finish_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'h296A));
    do_reset(1'b0);
    rd_reg(CTRL_OFFSET, 8'h00);
    rd_reg(INFO_OFFSET, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(CTRL_OFFSET, {5'h0, 3'($urandom % 7) + 3'h1});
      rd_reg(CTRL_OFFSET, 8'h00);
    end
    chk("irq", 0, {31'h0, irq});
    rd_reg(STAT_OFFSET, 8'h02);
    wr(MASK_OFFSET, 8'h02);
    chk("irq", 1, {31'h0, irq});
    wr(STAT_OFFSET, 8'h02);
    chk("irq", 0, {31'h0, irq});
    s_axi_wstrb <= 4'h0;
    wr(MASK_OFFSET, 8'h03);
    s_axi_wstrb <= 4'hF;
    rd_reg(MASK_OFFSET, 8'h02);
    rd_reg(8'h14, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'hFF, RESP_SLVERR);
    $display("test registers done");

    wr(CTRL_OFFSET, 8'hE8);
    rd_reg(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h00);
    rd_reg(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    // The window still stands in its fourth cycle and is shut two cycles later.
    rd_reg(CTRL_OFFSET, 8'h18);
    rd_reg(CTRL_OFFSET, 8'h18);
    rd_reg(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h00);
    rd_reg(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h05);
    rd_reg(CTRL_OFFSET, 8'h05);
    // A low clock enable freezes the window, so the disable after the gap still lands.
    wr(CTRL_OFFSET, 8'h1D);
    clk_en <= 1'b0;
    repeat (10) @(posedge aclk);
    clk_en <= 1'b1;
    wr(CTRL_OFFSET, 8'h05);
    rd_reg(CTRL_OFFSET, 8'h05);
    p = pulses;
    repeat (300) @(posedge aclk);
    chk("pulses off", p, pulses);
    $display("test unlock done");

    for (int s = 0; s < 8; s++) begin
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h08 | 8'(s));
      wait_pulse();
      wait_pulse();
      chk("period", BASE << s, gap);
    end
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h08);
    wait_pulse();
    p = pulses;
    repeat (6) begin
      repeat (16) @(posedge aclk);
      wr(KICK_OFFSET, 8'h01);
    end
    chk("kicked", p, pulses);
    rd_reg(STAT_OFFSET, 8'h03);
    chk("irq", 1, {31'h0, irq});
    $display("test timeout done");

    do_reset(1'b1);
    rd_reg(CTRL_OFFSET, 8'h08);
    rd_reg(INFO_OFFSET, 8'h03);
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h02);
    rd_reg(CTRL_OFFSET, 8'h0A);
    wait_pulse();
    wait_pulse();
    chk("level two period", BASE << 2, gap);
    $display("test safety level done");
    finish_test();
  end
endmodule

// file: tb/watchdog_ctrl_sva.sv
// Port checker of the watchdog control block and its bind.
module watchdog_ctrl_sva
  import wdt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        safety_level_fuse,
  input wire logic        chip_reset_req,
  input wire logic        irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [3:0] since_rst_r;

  // The safety level settles a few enabled cycles after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) since_rst_r <= 4'h0;
    else if (clk_en && since_rst_r != 4'h8) since_rst_r <= since_rst_r + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_after_exec;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_OFFSET;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_write_resp_time: assert property (write_taken |=> resp_after_exec)
    else $error("write response not two cycles after the write was taken");
  a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after the address was taken");
  a_write_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response is pending");
  a_read_busy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while read data is pending");
  a_unmapped_read_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > INFO_OFFSET[7:2]
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not answered with an error and zero");
  a_reserved_read_zero: assert property (ctrl_read |=> s_axi_rdata[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  a_level_two_on: assert property (
    ctrl_read and (safety_level_fuse && since_rst_r == 4'h8) |=> s_axi_rdata[TIMER_ON_BIT])
    else $error("timer on bit reads zero at the high safety level");
  a_reset_pulse_gap: assert property (chip_reset_req |=> !chip_reset_req [*6])
    else $error("reset request pulses too close together");
  a_reset_quiet_out: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !chip_reset_req && !irq)
    else $error("outputs active right after reset");
endmodule

bind watchdog_ctrl watchdog_ctrl_sva watchdog_ctrl_sva_inst (.*);
